//--- design/sbsc_pkg.sv
package sbsc_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int BURST_W = 2;
  localparam logic [LANES-1:0] LANES_ALL = 4'hf;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;
  localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    SBSC_OP_IDLE = 3'b000,
    SBSC_OP_DESEL = 3'b001,
    SBSC_OP_BEGIN = 3'b010,
    SBSC_OP_NEXT = 3'b011,
    SBSC_OP_HOLD = 3'b100
  } sbsc_op_e;
endpackage : sbsc_pkg

//--- design/sbsc_cycle_ctrl.sv
`timescale 1ns/1ps
module sbsc_cycle_ctrl (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [sbsc_pkg::ADDR_W-1:0] addr_in,
  input wire logic [sbsc_pkg::DATA_W-1:0] data_in,
  input wire logic global_write_n,
  input wire logic byte_write_enable_n,
  input wire logic [sbsc_pkg::LANES-1:0] lane_write_n,
  input wire logic chip_enable_low,
  input wire logic chip_enable_high,
  input wire logic chip_enable_third_low,
  input wire logic cpu_address_strobe_n,
  input wire logic cache_ctrl_address_strobe_n,
  input wire logic burst_step_n,
  input wire logic output_enable_n,
  input wire logic flow_through_select_n,
  input wire logic linear_order_select_n,
  input wire logic [sbsc_pkg::DATA_W-1:0] array_rdata,
  output logic [sbsc_pkg::ADDR_W-1:0] array_addr,
  output logic [sbsc_pkg::LANES-1:0] array_we,
  output logic [sbsc_pkg::DATA_W-1:0] array_wdata,
  output logic array_active,
  output logic [sbsc_pkg::DATA_W-1:0] dq_out,
  output logic [sbsc_pkg::LANES-1:0] dq_oe,
  output logic deselected
);

  typedef struct packed {
    logic [sbsc_pkg::ADDR_W-1:0] base;
    logic [sbsc_pkg::BURST_W-1:0] start;
    logic [sbsc_pkg::BURST_W-1:0] count;
    logic [sbsc_pkg::ADDR_W-1:0] addr;
    logic [sbsc_pkg::LANES-1:0] we;
    logic [sbsc_pkg::DATA_W-1:0] wdata;
    logic active;
    logic rd;
    logic rd_pipe;
    logic [sbsc_pkg::DATA_W-1:0] dout;
    logic desel;
    logic burst_open;
  } sbsc_state_s;

  sbsc_state_s state_q;
  sbsc_state_s state_d;

  // Mode straps are asynchronous to the core clock; while reset is held
  // they read as the pulled-up default (interleaved, pipelined)
  logic [1:0] ft_sync_q;
  logic [1:0] lbo_sync_q;
  logic flow_through_mode;
  logic linear_mode;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ft_sync_q <= '1;
      lbo_sync_q <= '1;
    end else begin
      ft_sync_q <= {ft_sync_q[0], flow_through_select_n};
      lbo_sync_q <= {lbo_sync_q[0], linear_order_select_n};
    end
  end

  // Straps are meant to be tied; a change mid-burst takes two cycles to show
  assign flow_through_mode = !ft_sync_q[1];
  assign linear_mode = !lbo_sync_q[1];

  logic enable_true;
  logic write_true;
  logic [sbsc_pkg::LANES-1:0] lane_we;
  sbsc_pkg::sbsc_op_e op;
  logic [sbsc_pkg::BURST_W-1:0] next_count;
  logic [sbsc_pkg::BURST_W-1:0] offset;
  logic [sbsc_pkg::ADDR_W-1:0] next_addr;

  // Strobe decode terms
  logic desel_ctrl;
  logic desel_false;
  logic begin_cpu;
  logic begin_ctrl;
  logic is_write;

  // byte write decode, one lane at a time
  for (genvar lane = 0; lane < sbsc_pkg::LANES; lane++) begin : g_lane
    logic lane_hit;
    always_comb begin
      if (!global_write_n) begin
        lane_hit = 1'b1;
      end else if (byte_write_enable_n) begin
        lane_hit = 1'b0;
      end else begin
        lane_hit = !lane_write_n[lane];
      end
    end
    assign lane_we[lane] = lane_hit;
  end

  // all lane inputs high leaves the cycle a read unless global write is low
  assign write_true = (lane_we != sbsc_pkg::LANES_NONE);
  assign enable_true = chip_enable_high && !chip_enable_third_low;

  // controller strobe with first enable high deselects
  assign desel_ctrl = chip_enable_low && !cache_ctrl_address_strobe_n;
  // false composite enable with either strobe deselects
  assign desel_false = !chip_enable_low && !enable_true
                       && (!cpu_address_strobe_n || !cache_ctrl_address_strobe_n);
  // cpu strobe wins while first enable is low
  assign begin_cpu = !chip_enable_low && enable_true && !cpu_address_strobe_n;
  // controller strobe begins only with the cpu strobe idle
  assign begin_ctrl = !chip_enable_low && enable_true && cpu_address_strobe_n
                      && !cache_ctrl_address_strobe_n;

  // Deselect rows are tested first so no begin row can shadow them
  always_comb begin
    if (desel_ctrl || desel_false) begin
      op = sbsc_pkg::SBSC_OP_DESEL;
    end else if (begin_cpu || begin_ctrl) begin
      op = sbsc_pkg::SBSC_OP_BEGIN;
    end else if (!burst_step_n) begin
      op = sbsc_pkg::SBSC_OP_NEXT;
    end else begin
      op = sbsc_pkg::SBSC_OP_HOLD;
    end
  end

  // Cpu strobe begin is always a read, whatever the write decode
  assign is_write = write_true && !begin_cpu;

  // wraps to the start after four steps
  assign next_count = state_q.count + sbsc_pkg::BURST_ONE;

  always_comb begin
    if (linear_mode) begin
      offset = next_count + state_q.start; // linear
    end else begin
      offset = next_count ^ state_q.start; // interleaved
    end
  end

  // Upper address bits come from the captured base; only the low pair counts
  assign next_addr = {state_q.base[sbsc_pkg::ADDR_W-1:sbsc_pkg::BURST_W], offset};

  always_comb begin
    state_d = state_q;
    state_d.we = sbsc_pkg::LANES_NONE;
    state_d.active = 1'b0;
    state_d.rd = 1'b0;
    state_d.desel = 1'b0;
    case (op)
      sbsc_pkg::SBSC_OP_DESEL: begin
        state_d.desel = 1'b1;
        state_d.burst_open = 1'b0;
      end
      sbsc_pkg::SBSC_OP_BEGIN: begin
        state_d.base = addr_in;
        state_d.start = addr_in[sbsc_pkg::BURST_W-1:0];
        state_d.count = sbsc_pkg::BURST_ZERO;
        state_d.addr = addr_in;
        state_d.burst_open = 1'b1;
        state_d.active = 1'b1;
        state_d.rd = !is_write;
        if (is_write) begin
          state_d.we = lane_we;
        end
      end
      sbsc_pkg::SBSC_OP_NEXT: begin
        // counter steps regardless of output enable
        state_d.count = next_count;
        state_d.addr = next_addr;
        state_d.active = state_q.burst_open;
        if (state_q.burst_open && write_true) begin
          state_d.we = lane_we;
        end else begin
          state_d.rd = state_q.burst_open;
        end
      end
      sbsc_pkg::SBSC_OP_HOLD: begin
        // Counter held, same address reused
        state_d.active = state_q.burst_open;
        if (state_q.burst_open && write_true) begin
          state_d.we = lane_we;
        end else begin
          state_d.rd = state_q.burst_open;
        end
      end
      default: begin
        state_d.desel = 1'b1;
      end
    endcase
    state_d.wdata = data_in;
    // pipelined read data registered one more stage
    state_d.dout = array_rdata;
    // deselect or write clears the pipe stage at once
    state_d.rd_pipe = state_q.rd && !state_d.desel && (state_d.we == sbsc_pkg::LANES_NONE);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign array_addr = state_q.addr;
  assign array_we = state_q.we;
  assign array_wdata = state_q.wdata;
  assign array_active = state_q.active;
  assign deselected = state_q.desel;

  logic drive_cycle;
  logic read_slot;

  always_comb begin
    if (flow_through_mode) begin
      dq_out = array_rdata; // flow-through bypass
      drive_cycle = state_q.rd;
    end else begin
      dq_out = state_q.dout; // registered
      drive_cycle = state_q.rd_pipe;
    end
  end

  // a write in the array stage keeps every lane released
  assign read_slot = drive_cycle && (state_q.we == sbsc_pkg::LANES_NONE);

  // raw pin gates drivers off; a synchroniser here would leave the
  // drivers on for two cycles after the pin rises and fight write data
  for (genvar lane = 0; lane < sbsc_pkg::LANES; lane++) begin : g_drive
    assign dq_oe[lane] = read_slot && !output_enable_n;
  end

endmodule : sbsc_cycle_ctrl

//--- test/sbsc_cycle_ctrl_checker.sv
`timescale 1ns/1ps
module sbsc_cycle_ctrl_checker (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [15:0] addr_in,
  input wire logic global_write_n,
  input wire logic byte_write_enable_n,
  input wire logic [3:0] lane_write_n,
  input wire logic chip_enable_low,
  input wire logic chip_enable_high,
  input wire logic chip_enable_third_low,
  input wire logic cpu_address_strobe_n,
  input wire logic cache_ctrl_address_strobe_n,
  input wire logic burst_step_n,
  input wire logic output_enable_n,
  input wire logic linear_order_select_n,
  input wire logic [15:0] array_addr,
  input wire logic [3:0] array_we,
  input wire logic array_active,
  input wire logic [3:0] dq_oe,
  input wire logic deselected
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire logic en_t = !chip_enable_low && chip_enable_high && !chip_enable_third_low;
  wire logic wr_beg = en_t && cpu_address_strobe_n && !cache_ctrl_address_strobe_n;
  // Open burst only; a deselect closes it
  wire logic go_on = cpu_address_strobe_n && cache_ctrl_address_strobe_n && array_active;
  oe_off_a: assert property (output_enable_n |-> dq_oe == 4'h0)
    else $error("drivers on with oe high");
  desel_hiz_a: assert property (deselected |-> dq_oe == 4'h0)
    else $error("drivers on when deselected");
  desel_one_a: assert property (chip_enable_low && !cache_ctrl_address_strobe_n |=> deselected)
    else $error("no deselect");
  gw_all_a: assert property (wr_beg && !global_write_n |=> array_we == 4'hf)
    else $error("global write lanes");
  lane_we_a: assert property (wr_beg && global_write_n && !byte_write_enable_n
    |=> array_we == ~$past(lane_write_n)) else $error("lane write");
  rd_no_we_a: assert property (global_write_n && byte_write_enable_n |=> array_we == 4'h0)
    else $error("write on read decode");
  cpu_beg_a: assert property (en_t && !cpu_address_strobe_n
    |=> array_active && array_we == 4'h0 && array_addr == $past(addr_in)) else $error("cpu begin");
  lin_next_a: assert property (go_on && !burst_step_n && !linear_order_select_n
    |=> array_addr[1:0] == $past(array_addr[1:0]) + 2'h1) else $error("linear step");
  hold_a: assert property (go_on && burst_step_n |=> $stable(array_addr))
    else $error("suspend moved address");
  burst_gw_a: assert property (go_on && !global_write_n |=> array_we == 4'hf)
    else $error("burst global write lanes");
endmodule : sbsc_cycle_ctrl_checker
bind sbsc_cycle_ctrl sbsc_cycle_ctrl_checker sbsc_cycle_ctrl_checker_i (.*);

//--- test/sbsc_array_model.sv
`timescale 1ns/1ps
module sbsc_array_model (
  input wire logic core_clk,
  input wire logic [15:0] addr,
  input wire logic [3:0] we,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata
);
  // Small store: address bits above 3 alias
  logic [31:0] mem [16];
  assign rdata = mem[addr[3:0]];
  always @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (we[i]) mem[addr[3:0]][8*i+:8] <= wdata[8*i+:8];
    end
  end
endmodule : sbsc_array_model

//--- test/sync_burst_sram_cycle_control_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module sync_burst_sram_cycle_control_bench;
  logic core_clk = 1'b0, resetn = 1'b0, oe_v = 1'b0;
  logic [15:0] addr_in = 16'h0, array_addr, hold_a;
  logic [31:0] data_in = 32'h0, array_rdata, array_wdata, dq_out, lf = 32'h28, wd, rd;
  logic global_write_n = 1'b1, byte_write_enable_n = 1'b1, chip_enable_low = 1'b1;
  logic chip_enable_high = 1'b1, chip_enable_third_low = 1'b0, cpu_address_strobe_n = 1'b1;
  logic cache_ctrl_address_strobe_n = 1'b0, burst_step_n = 1'b1, output_enable_n = 1'b0;
  logic flow_through_select_n = 1'b0, linear_order_select_n = 1'b0, array_active, deselected;
  logic [3:0] lane_write_n = 4'hf, array_we, dq_oe;
  logic [1:0] en_v = 2'h2;
  int err_count = 0, samples_checked = 0, cycles = 0;
  sbsc_cycle_ctrl sbsc_cycle_ctrl_i (.core_clk, .resetn, .addr_in, .data_in, .global_write_n,
    .byte_write_enable_n, .lane_write_n, .chip_enable_low, .chip_enable_high,
    .chip_enable_third_low, .cpu_address_strobe_n, .cache_ctrl_address_strobe_n, .burst_step_n,
    .output_enable_n, .flow_through_select_n, .linear_order_select_n, .array_rdata, .array_addr,
    .array_we, .array_wdata, .array_active, .dq_out, .dq_oe, .deselected);
  sbsc_array_model sbsc_array_model_i (.core_clk, .addr(array_addr), .we(array_we),
    .wdata(array_wdata), .rdata(array_rdata));
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  function automatic logic [31:0] nx(logic [31:0] s);
    repeat (8) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction : nx
  function automatic logic [1:0] off(logic [1:0] s, logic [1:0] n, logic lo);
    return lo ? s ^ n : s + n;
  endfunction : off
  // Outputs seen on return belong to the previous call's command
  task automatic cyc(logic ce, cp, cc, st, gl, logic [4:0] wb, logic [15:0] a, logic [31:0] d);
    @(posedge core_clk);
    {chip_enable_low, cpu_address_strobe_n, cache_ctrl_address_strobe_n, burst_step_n} <= {ce, cp, cc, st};
    {output_enable_n, global_write_n, byte_write_enable_n, lane_write_n} <= {oe_v, gl, wb};
    {addr_in, data_in} <= {a, d};
    {chip_enable_high, chip_enable_third_low} <= en_v;
    #1;
  endtask : cyc
  task automatic rst(logic ft, logic lo);
    @(posedge core_clk);
    resetn <= 1'b0;
    {flow_through_select_n, linear_order_select_n} <= {ft, lo};
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) cyc(1, 1, 0, 1, 1, 5'h1f, 16'h0, 32'h0);
  endtask : rst
  task automatic burst(logic [1:0] s, logic lo);
    cyc(0, 1, 0, 1, 1, 5'h1f, {14'h0, s}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      cyc(1, 1, 1, 0, 1, 5'h1f, 16'hffff, 32'h0);
      `CHK("burst addr", off(s, i[1:0], lo), array_addr[1:0])
      if (oe_v) `CHK("oe off", 4'h0, dq_oe)
    end
    cyc(1, 1, 1, 1, 1, 5'h1f, 16'h0, 32'h0);
    hold_a = array_addr;
    cyc(1, 1, 0, 1, 1, 5'h1f, 16'h0, 32'h0);
    `CHK("hold addr", hold_a, array_addr)
  endtask : burst
  initial begin
    rst(0, 0);
    wd = nx(lf);
    rd = nx(wd);
    cyc(0, 1, 0, 1, 0, 5'h1f, 16'h0005, wd);
    cyc(0, 1, 0, 1, 1, 5'h0a, 16'h0005, rd);
    `CHK("gw lanes", 4'hf, array_we)
    `CHK("write hiz", 4'h0, dq_oe)
    cyc(0, 1, 0, 1, 1, 5'h1f, 16'h0005, 32'h0);
    `CHK("byte lanes", 4'h5, array_we)
    cyc(1, 1, 0, 1, 1, 5'h1f, 16'h0, 32'h0);
    `CHK("flow data", {wd[31:24], rd[23:16], wd[15:8], rd[7:0]}, dq_out)
    `CHK("read oe", 4'hf, dq_oe)
    cyc(1, 1, 0, 1, 1, 5'h1f, 16'h0, 32'h0);
    `CHK("deselect", 1'b1, deselected)
    `CHK("desel hiz", 4'h0, dq_oe)
    oe_v = 1'b1;
    burst(2'h2, 1'b0);
    oe_v = 1'b0;
    rst(1, 1);
    cyc(0, 0, 1, 1, 0, 5'h00, 16'h0005, 32'h0);
    cyc(1, 1, 1, 1, 1, 5'h1f, 16'h0, 32'h0);
    `CHK("pipe early", 4'h0, dq_oe)
    cyc(1, 1, 1, 1, 1, 5'h1f, 16'h0, 32'h0);
    `CHK("pipe data", {wd[31:24], rd[23:16], wd[15:8], rd[7:0]}, dq_out)
    burst(2'h1, 1'b1);
    rst(0, 0);
    repeat (300) begin
      lf = nx(lf);
      oe_v = lf[9];
      en_v = lf[11:10];
      cyc(lf[0], lf[1], lf[2], lf[3], lf[4], lf[14:10], lf[31:16], ~lf);
    end
    conclude();
  end
endmodule : sync_burst_sram_cycle_control_bench
